// ### hdl/bank_map.sv
module bank_map (
  input  wire logic       mem_bank_enable_i,
  input  wire logic [3:0] memory_bank_select_i,
  input  wire logic [7:0] addr_i,
  output logic            ram_hit_o,
  output logic            io_hit_o,
  output logic [8:0]      ram_index_o
);

  always_comb begin
    ram_hit_o   = 1'b0;
    io_hit_o    = 1'b0;
    ram_index_o = {1'b0, addr_i};
    if (!mem_bank_enable_i) begin
      ram_hit_o = !addr_i[7];
      io_hit_o  = addr_i[7];
    end else begin
      case (memory_bank_select_i)
        cpu_state_pkg::BANK_ZERO: ram_hit_o = 1'b1;
        cpu_state_pkg::BANK_ONE: begin
          ram_hit_o   = 1'b1;
          ram_index_o = {1'b1, addr_i};
        end
        cpu_state_pkg::BANK_IO: io_hit_o = addr_i[7];
        default: ram_hit_o = 1'b0;
      endcase
    end
  end

endmodule : bank_map

// ### hdl/cpu_state.sv
// The Wishbone slave port and the register offsets are this design's own decisions.
module cpu_state (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        fetch_i,
  input  wire logic [1:0]  fetch_len_i,
  input  wire logic        table_ref_i,
  input  wire logic [13:0] ref_addr_i,
  input  wire logic [1:0]  ref_len_i,
  input  wire logic        call_i,
  input  wire logic [13:0] call_target_i,
  input  wire logic        int_entry_i,
  input  wire logic [13:0] vector_i,
  input  wire logic        ret_i,
  input  wire logic        acc_req_i,
  input  wire logic        acc_we_i,
  input  wire logic        acc_reg_i,
  input  wire logic        acc_ind_i,
  input  wire logic [1:0]  acc_size_i,
  input  wire logic [7:0]  acc_addr_i,
  input  wire logic [2:0]  acc_bit_i,
  input  wire logic [7:0]  acc_wdata_i,
  input  wire logic        alu_go_i,
  input  wire logic        alu_wide_i,
  input  wire logic [2:0]  alu_op_i,
  input  wire logic [7:0]  alu_a_i,
  input  wire logic [7:0]  alu_b_i,
  input  wire logic        skip_load_i,
  input  wire logic [2:0]  skip_i,
  input  wire logic        smb_load_i,
  input  wire logic [3:0]  smb_i,
  input  wire logic        srb_load_i,
  input  wire logic [1:0]  srb_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic             wb_ack_o,
  output logic [31:0]      wb_dat_o,
  output logic [13:0]      fetch_pointer_o,
  output logic [7:0]       program_state_word_o,
  output logic [7:0]       stack_index_o,
  output logic [11:0]      bank_base_o,
  output logic             stack_busy_o,
  output logic             stack_done_o,
  output logic             acc_done_o,
  output logic             acc_err_o,
  output logic [7:0]       acc_rdata_o,
  output logic             alu_done_o,
  output logic [7:0]       alu_y_o,
  output logic             tref_ok_o,
  output logic             tref_err_o
);

  typedef struct packed {
    logic [13:0]                fp;
    logic [7:0]                 sp;
    logic [7:0]                 program_state_word;
    logic [7:0]                 bw;
    logic [3:0]                 memory_bank_select;
    logic [1:0]                 srb;
    cpu_state_pkg::stack_state_t st;
    logic                       busy;
    logic [2:0]                 cnt;
    logic [23:0]                frame;
    logic                       stack_done;
    logic                       acc_done;
    logic                       acc_err;
    logic [7:0]                 acc_rdata;
    cpu_state_pkg::alu_state_t  alu;
    cpu_state_pkg::alu_op_t     alu_op;
    logic [7:0]                 alu_a;
    logic                       alu_c;
    logic [7:0]                 alu_y;
    logic                       alu_done;
    logic                       tref_ok;
    logic                       tref_err;
    logic                       wb_ack;
    logic [31:0]                wb_dat;
  } state_t;

  state_t      q;
  state_t      nxt;
  logic        map_ram_hit;
  logic        map_io_hit;
  logic [8:0]  map_index;
  logic [1:0]  srb_eff;
  logic [8:0]  acc_index;
  logic [8:0]  ram_index;
  logic [7:0]  ram_rd;
  logic        ram_we;
  logic        ram_wide;
  logic [7:0]  ram_wdata;
  logic [3:0]  ram_wmask;
  logic        acc_take;
  logic        sz_byte;
  logic        sz_nib;
  logic        sz_bit;
  logic        is_psw;
  logic        ram_tgt;
  logic        bad_acc;
  logic [2:0]  bitpos;
  logic [7:0]  io_view;
  logic [7:0]  io_wmask;
  logic [7:0]  sel8;
  logic [7:0]  wsh;
  logic [7:0]  io_new;
  logic [4:0]  alu_r;
  logic        alu_cin;
  logic        alu_arith;
  logic        alu_rot;

  // ==========================================================
  // Data memory path
  bank_map u_bank_map (
    .mem_bank_enable_i    (q.program_state_word[cpu_state_pkg::PSW_EMB]),
    .memory_bank_select_i (q.memory_bank_select),
    .addr_i               (acc_addr_i),
    .ram_hit_o            (map_ram_hit),
    .io_hit_o             (map_io_hit),
    .ram_index_o          (map_index)
  );

  assign srb_eff   = q.program_state_word[cpu_state_pkg::PSW_ERB] ? q.srb : 2'b00;
  assign acc_index = acc_reg_i ? {4'h0, srb_eff, acc_addr_i[2:0]} : map_index;
  assign sz_bit    = acc_ind_i || (acc_size_i == cpu_state_pkg::SZ_BIT);
  assign sz_nib    = !acc_ind_i && (acc_size_i == cpu_state_pkg::SZ_NIB);
  assign sz_byte   = !acc_ind_i && (acc_size_i == cpu_state_pkg::SZ_BYTE);
  assign is_psw    = !acc_reg_i && !acc_ind_i
                     && (acc_addr_i[7:1] == cpu_state_pkg::PSW_LOC[7:1]);
  assign ram_tgt   = !acc_ind_i && !is_psw && (acc_reg_i || map_ram_hit);
  assign bad_acc   = (!sz_bit && !sz_nib && !sz_byte) || (sz_byte && acc_addr_i[0])
                     || (!acc_reg_i && !acc_ind_i && !is_psw && !map_ram_hit && !map_io_hit)
                     || (is_psw && sz_byte && acc_we_i);
  assign acc_take  = acc_req_i && (q.st == cpu_state_pkg::ST_IDLE);

  // Stack always addresses bank 0, bypassing the bank map
  assign ram_index = (q.st == cpu_state_pkg::ST_PUSH) ?
                       {1'b0, 8'(q.sp - 8'h01 - {5'h00, q.cnt})} :
                     (q.st == cpu_state_pkg::ST_POP) ?
                       {1'b0, 8'(q.sp + {5'h00, q.cnt})} : acc_index;
  assign ram_we    = (q.st == cpu_state_pkg::ST_PUSH)
                     || (acc_take && acc_we_i && ram_tgt && !bad_acc);
  assign ram_wide  = (q.st == cpu_state_pkg::ST_IDLE) && sz_byte;
  assign ram_wdata = (q.st == cpu_state_pkg::ST_PUSH) ?
                       {4'h0, q.frame[{q.cnt, 2'b00} +: 4]} :
                     sz_bit ? {4'h0, {4{acc_wdata_i[0]}}} : acc_wdata_i;
  assign ram_wmask = ((q.st == cpu_state_pkg::ST_IDLE) && sz_bit) ?
                       4'(4'h1 << acc_bit_i[1:0]) : 4'hF;

  data_ram u_data_ram (
    .clk_i   (clk_i),
    .we_i    (ram_we),
    .wide_i  (ram_wide),
    .index_i (ram_index),
    .wdata_i (ram_wdata),
    .wmask_i (ram_wmask),
    .rdata_o (ram_rd)
  );

  // ==========================================================
  // Bank-15 register view
  assign bitpos = acc_ind_i ? acc_bit_i : {acc_addr_i[0], acc_bit_i[1:0]};
  assign sel8   = sz_byte ? 8'hFF : sz_nib ? (acc_addr_i[0] ? 8'hF0 : 8'h0F)
                  : 8'(8'h01 << bitpos);
  assign wsh    = sz_byte ? acc_wdata_i : sz_nib ? {2{acc_wdata_i[3:0]}}
                  : {8{acc_wdata_i[0]}};

  always_comb begin
    io_view  = 8'h00;
    io_wmask = 8'h00;
    if (acc_ind_i || (acc_addr_i[7:1] == cpu_state_pkg::BW_LOC[7:1])) begin
      io_view  = q.bw;
      io_wmask = 8'hFF;
    end else if (is_psw) begin
      // Skip bits are seen only through a byte read
      io_view  = sz_byte ? q.program_state_word : (q.program_state_word & cpu_state_pkg::PSW_RW_MASK);
      io_wmask = sz_byte ? 8'h00 : cpu_state_pkg::PSW_RW_MASK;
    end else if (acc_addr_i[7:1] == cpu_state_pkg::SP_LOC[7:1]) begin
      io_view  = q.sp;
      io_wmask = cpu_state_pkg::SP_WMASK;
    end
  end

  assign io_new = (io_view & ~(sel8 & io_wmask)) | (wsh & sel8 & io_wmask);

  // ==========================================================
  // ALU nibble slice
  assign alu_arith = (q.alu_op == cpu_state_pkg::ALU_ADD) || (q.alu_op == cpu_state_pkg::ALU_SUB);
  assign alu_rot   = (q.alu_op == cpu_state_pkg::ALU_RL) || (q.alu_op == cpu_state_pkg::ALU_RR);

  function automatic logic [4:0] alu4(input cpu_state_pkg::alu_op_t op,
                                      input logic [3:0] a,
                                      input logic [3:0] b,
                                      input logic       cin);
    logic [4:0] r;
    r = 5'h00;
    case (op)
      cpu_state_pkg::ALU_ADD: r = 5'({1'b0, a} + {1'b0, b} + {4'h0, cin});
      cpu_state_pkg::ALU_SUB: r = 5'({1'b0, a} - {1'b0, b} - {4'h0, cin});
      cpu_state_pkg::ALU_AND: r = {1'b0, a & b};
      cpu_state_pkg::ALU_OR:  r = {1'b0, a | b};
      cpu_state_pkg::ALU_XOR: r = {1'b0, a ^ b};
      cpu_state_pkg::ALU_RL:  r = {a[3], a[2:0], cin};
      cpu_state_pkg::ALU_RR:  r = {a[0], cin, a[3:1]};
      default:                r = 5'h00;
    endcase
    return r;
  endfunction : alu4

  always_comb begin
    alu_cin = 1'b0;
    if (q.alu == cpu_state_pkg::ALU_HIGH) begin
      if (alu_arith) alu_cin = q.alu_c;
      else if (q.alu_op == cpu_state_pkg::ALU_RL) alu_cin = q.alu_a[3];
      else if (q.alu_op == cpu_state_pkg::ALU_RR) alu_cin = q.alu_a[0];
    end else if (alu_wide_i) begin
      if (alu_op_i == cpu_state_pkg::ALU_RL) alu_cin = alu_a_i[7];
      else if (alu_op_i == cpu_state_pkg::ALU_RR) alu_cin = alu_a_i[4];
    end else begin
      if (alu_op_i == cpu_state_pkg::ALU_RL) alu_cin = alu_a_i[3];
      else if (alu_op_i == cpu_state_pkg::ALU_RR) alu_cin = alu_a_i[0];
    end
  end

  assign alu_r = (q.alu == cpu_state_pkg::ALU_HIGH) ?
                 alu4(q.alu_op, q.alu_a[7:4], q.alu_y[7:4], alu_cin) :
                 alu4(cpu_state_pkg::alu_op_t'(alu_op_i), alu_a_i[3:0], alu_b_i[3:0], alu_cin);

  // ==========================================================
  // Next state
  always_comb begin
    nxt            = q;
    nxt.stack_done = 1'b0;
    nxt.acc_done   = 1'b0;
    nxt.acc_err    = 1'b0;
    nxt.alu_done   = 1'b0;
    nxt.tref_ok    = 1'b0;
    nxt.tref_err   = 1'b0;
    nxt.wb_ack     = 1'b0;

    if (fetch_i && (q.st == cpu_state_pkg::ST_IDLE)) begin
      if (table_ref_i) begin
        // Pointer holds; the entry must lie in the table and be short
        if ((ref_addr_i >= cpu_state_pkg::TREF_FIRST) && (ref_addr_i <= cpu_state_pkg::TREF_LAST)
            && ((ref_len_i == cpu_state_pkg::REF_LEN_ONE)
                || (ref_len_i == cpu_state_pkg::REF_LEN_TWO))) begin
          nxt.tref_ok = 1'b1;
        end else begin
          nxt.tref_err = 1'b1;
        end
      end else begin
        nxt.fp = 14'(q.fp + {12'h000, fetch_len_i});
      end
    end

    case (q.st)
      cpu_state_pkg::ST_IDLE: begin
        nxt.cnt = 3'h0;
        if (int_entry_i || call_i) begin
          nxt.frame = {2'b00, q.fp, q.program_state_word};
          nxt.fp    = int_entry_i ? vector_i : call_target_i;
          nxt.st    = cpu_state_pkg::ST_PUSH;
        end else if (ret_i) begin
          nxt.st = cpu_state_pkg::ST_POP;
        end
      end
      cpu_state_pkg::ST_PUSH: begin
        nxt.cnt = 3'(q.cnt + 3'h1);
        if (q.cnt == cpu_state_pkg::STACK_LAST) begin
          nxt.sp         = 8'(q.sp - cpu_state_pkg::STACK_NIBBLES);
          nxt.st         = cpu_state_pkg::ST_IDLE;
          nxt.stack_done = 1'b1;
        end
      end
      cpu_state_pkg::ST_POP: begin
        nxt.cnt = 3'(q.cnt + 3'h1);
        nxt.frame[{3'(cpu_state_pkg::STACK_LAST - q.cnt), 2'b00} +: 4] = ram_rd[3:0];
        if (q.cnt == cpu_state_pkg::STACK_LAST) begin
          nxt.fp         = nxt.frame[21:8];
          nxt.program_state_word        = nxt.frame[7:0];
          nxt.sp         = 8'(q.sp + cpu_state_pkg::STACK_NIBBLES);
          nxt.st         = cpu_state_pkg::ST_IDLE;
          nxt.stack_done = 1'b1;
        end
      end
      default: nxt.st = cpu_state_pkg::ST_IDLE;
    endcase
    nxt.busy = (nxt.st != cpu_state_pkg::ST_IDLE);

    // Requests during a stack sequence are answered with an error
    if (acc_req_i) begin
      nxt.acc_done  = 1'b1;
      nxt.acc_err   = !acc_take || bad_acc;
      nxt.acc_rdata = 8'h00;
      if (acc_take && !bad_acc) begin
        if (ram_tgt) begin
          nxt.acc_rdata = sz_byte ? ram_rd : sz_nib ? {4'h0, ram_rd[3:0]}
                          : {7'h00, ram_rd[acc_bit_i[1:0]]};
        end else begin
          nxt.acc_rdata = sz_byte ? io_view
                          : sz_nib ? {4'h0, (acc_addr_i[0] ? io_view[7:4] : io_view[3:0])}
                          : {7'h00, io_view[bitpos]};
          if (acc_we_i) begin
            if (acc_ind_i || (acc_addr_i[7:1] == cpu_state_pkg::BW_LOC[7:1])) begin
              nxt.bw = io_new;
            end else if (is_psw) begin
              nxt.program_state_word = (q.program_state_word & ~cpu_state_pkg::PSW_RW_MASK)
                        | (io_new & cpu_state_pkg::PSW_RW_MASK);
            end else if (acc_addr_i[7:1] == cpu_state_pkg::SP_LOC[7:1]) begin
              nxt.sp = io_new & cpu_state_pkg::SP_WMASK;
            end
          end
        end
      end
    end

    // 4-bit result after one edge, 8-bit after two
    case (q.alu)
      cpu_state_pkg::ALU_IDLE: begin
        if (alu_go_i) begin
          nxt.alu_op = cpu_state_pkg::alu_op_t'(alu_op_i);
          nxt.alu_a  = alu_a_i;
          nxt.alu_c  = alu_r[4];
          if (alu_wide_i) begin
            nxt.alu_y = {alu_b_i[7:4], alu_r[3:0]};
            nxt.alu   = cpu_state_pkg::ALU_HIGH;
          end else begin
            nxt.alu_y    = {4'h0, alu_r[3:0]};
            nxt.alu_done = 1'b1;
            if ((alu_op_i == cpu_state_pkg::ALU_ADD) || (alu_op_i == cpu_state_pkg::ALU_SUB)
                || (alu_op_i == cpu_state_pkg::ALU_RL) || (alu_op_i == cpu_state_pkg::ALU_RR)) begin
              nxt.program_state_word[cpu_state_pkg::PSW_C] = alu_r[4];
            end
          end
        end
      end
      cpu_state_pkg::ALU_HIGH: begin
        nxt.alu_y    = {alu_r[3:0], q.alu_y[3:0]};
        nxt.alu_done = 1'b1;
        nxt.alu      = cpu_state_pkg::ALU_IDLE;
        if (alu_arith || alu_rot) begin
          nxt.program_state_word[cpu_state_pkg::PSW_C] = alu_r[4];
        end
      end
      default: nxt.alu = cpu_state_pkg::ALU_IDLE;
    endcase

    if (skip_load_i) begin
      nxt.program_state_word[2:0] = skip_i;
    end
    if (smb_load_i && ((smb_i == cpu_state_pkg::BANK_ZERO) || (smb_i == cpu_state_pkg::BANK_ONE)
                       || (smb_i == cpu_state_pkg::BANK_IO))) begin
      nxt.memory_bank_select = smb_i;
    end
    if (srb_load_i) begin
      nxt.srb = srb_i;
    end

    // Wishbone slave: one wait state, ack for one cycle
    if (wb_cyc_i && wb_stb_i && !q.wb_ack) begin
      nxt.wb_ack = 1'b1;
      nxt.wb_dat = 32'h0000_0000;
      case (wb_adr_i)
        cpu_state_pkg::REG_BANK_SEL: begin
          nxt.wb_dat = {26'h0000000, q.srb, q.memory_bank_select};
          if (wb_we_i && wb_sel_i[0]) begin
            nxt.srb = wb_dat_i[5:4];
            if ((wb_dat_i[3:0] == cpu_state_pkg::BANK_ZERO)
                || (wb_dat_i[3:0] == cpu_state_pkg::BANK_ONE)
                || (wb_dat_i[3:0] == cpu_state_pkg::BANK_IO)) begin
              nxt.memory_bank_select = wb_dat_i[3:0];
            end
          end
        end
        cpu_state_pkg::REG_FETCH:    nxt.wb_dat = {18'h00000, q.fp};
        cpu_state_pkg::REG_PSW:      nxt.wb_dat = {24'h000000, q.program_state_word};
        cpu_state_pkg::REG_STACK:    nxt.wb_dat = {24'h000000, q.sp};
        cpu_state_pkg::REG_BIT_WALK: nxt.wb_dat = {24'h000000, q.bw};
        default:                     nxt.wb_dat = 32'h0000_0000;
      endcase
    end

    if (rst_i) begin
      nxt     = '0;
      nxt.fp  = cpu_state_pkg::RESET_VECTOR;
      nxt.sp  = cpu_state_pkg::SP_RESET;
      nxt.program_state_word = cpu_state_pkg::PSW_RESET;
    end
  end

  always_ff @(posedge clk_i) begin
    q <= nxt;
  end

  // ==========================================================
  // Outputs
  assign wb_ack_o             = q.wb_ack;
  assign wb_dat_o             = q.wb_dat;
  assign fetch_pointer_o      = q.fp;
  assign program_state_word_o = q.program_state_word;
  assign stack_index_o        = q.sp;
  assign bank_base_o          = {q.memory_bank_select, 8'h00};
  assign stack_busy_o         = q.busy;
  assign stack_done_o         = q.stack_done;
  assign acc_done_o           = q.acc_done;
  assign acc_err_o            = q.acc_err;
  assign acc_rdata_o          = q.acc_rdata;
  assign alu_done_o           = q.alu_done;
  assign alu_y_o              = q.alu_y;
  assign tref_ok_o            = q.tref_ok;
  assign tref_err_o           = q.tref_err;

endmodule : cpu_state

// ### hdl/cpu_state_pkg.sv
package cpu_state_pkg;

  // ==========================================================
  // Fetch pointer and table-reference area
  localparam logic [13:0] RESET_VECTOR = 14'h0000;
  localparam logic [13:0] TREF_FIRST   = 14'h0020;
  localparam logic [13:0] TREF_LAST    = 14'h007F;
  localparam logic [1:0]  REF_LEN_ONE  = 2'h1;
  localparam logic [1:0]  REF_LEN_TWO  = 2'h2;

  // ==========================================================
  // Stack
  localparam logic [7:0] SP_RESET      = 8'h00;
  localparam logic [7:0] SP_WMASK      = 8'hFE;
  localparam logic [7:0] STACK_NIBBLES = 8'h06;
  localparam logic [2:0] STACK_LAST    = 3'h5;

  // ==========================================================
  // Program state word fields
  localparam int          PSW_ERB     = 4;
  localparam int          PSW_EMB     = 5;
  localparam int          PSW_C       = 3;
  localparam logic [7:0]  PSW_RESET   = 8'h00;
  localparam logic [7:0]  PSW_RW_MASK = 8'hF8;

  // ==========================================================
  // Data memory banks and bank-15 locations
  localparam logic [3:0] BANK_ZERO = 4'h0;
  localparam logic [3:0] BANK_ONE  = 4'h1;
  localparam logic [3:0] BANK_IO   = 4'hF;
  localparam logic [7:0] SP_LOC    = 8'h80;
  localparam logic [7:0] PSW_LOC   = 8'hB0;
  localparam logic [7:0] BW_LOC    = 8'hC0;

  // ==========================================================
  // Wishbone register byte offsets
  localparam logic [7:0] REG_BANK_SEL = 8'h00;
  localparam logic [7:0] REG_FETCH    = 8'h04;
  localparam logic [7:0] REG_PSW      = 8'h08;
  localparam logic [7:0] REG_STACK    = 8'h0C;
  localparam logic [7:0] REG_BIT_WALK = 8'h10;

  typedef enum logic [1:0] {
    SZ_BIT  = 2'b00,
    SZ_NIB  = 2'b01,
    SZ_BYTE = 2'b10
  } acc_size_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PUSH = 2'b01,
    ST_POP  = 2'b10
  } stack_state_t;

  typedef enum logic [2:0] {
    ALU_ADD = 3'b000,
    ALU_SUB = 3'b001,
    ALU_AND = 3'b010,
    ALU_OR  = 3'b011,
    ALU_XOR = 3'b100,
    ALU_RL  = 3'b101,
    ALU_RR  = 3'b110
  } alu_op_t;

  typedef enum logic {
    ALU_IDLE = 1'b0,
    ALU_HIGH = 1'b1
  } alu_state_t;

endpackage : cpu_state_pkg

// ### hdl/data_ram.sv
module data_ram (
  input  wire logic       clk_i,
  input  wire logic       we_i,
  input  wire logic       wide_i,
  input  wire logic [8:0] index_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic [3:0] wmask_i,
  output logic [7:0]      rdata_o
);

  // Contents are left undefined at reset on purpose
  typedef struct packed {
    logic [511:0][3:0] mem;
  } ram_t;

  ram_t       q;
  ram_t       nxt;
  logic [8:0] index_hi;

  assign index_hi = 9'(index_i + 9'h001);

  always_comb begin
    nxt     = q;
    rdata_o = {q.mem[index_hi], q.mem[index_i]};
    if (we_i) begin
      nxt.mem[index_i] = (q.mem[index_i] & ~wmask_i) | (wdata_i[3:0] & wmask_i);
      if (wide_i) begin
        nxt.mem[index_hi] = wdata_i[7:4];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    q <= nxt;
  end

endmodule : data_ram

// ### testbench/cpu_state_assertions.sv
module cpu_state_assertions (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        fetch_i,
  input wire logic [1:0]  fetch_len_i,
  input wire logic        table_ref_i,
  input wire logic        call_i,
  input wire logic        int_entry_i,
  input wire logic        ret_i,
  input wire logic [13:0] vector_i,
  input wire logic        alu_go_i,
  input wire logic        alu_wide_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic        wb_ack_o,
  input wire logic [13:0] fetch_pointer_o,
  input wire logic [7:0]  stack_index_o,
  input wire logic        stack_busy_o,
  input wire logic        stack_done_o,
  input wire logic        alu_done_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Fetch counts only when no stack command or register write competes
  wire f_ok = fetch_i && !stack_busy_o && !call_i && !int_entry_i && !ret_i
              && !(wb_cyc_i && wb_stb_i && wb_we_i);
  property p_sp0; stack_index_o[0] == 1'b0; endproperty
  a_sp0: assert property (p_sp0) else $error("stack index bit 0 set");
  property p_adv; f_ok && !table_ref_i |=>
    fetch_pointer_o == $past(fetch_pointer_o) + 14'($past(fetch_len_i)); endproperty
  a_adv: assert property (p_adv) else $error("fetch advance wrong");
  property p_ref; f_ok && table_ref_i |=> $stable(fetch_pointer_o); endproperty
  a_ref: assert property (p_ref) else $error("table fetch moved pointer");
  property p_vec; int_entry_i && !stack_busy_o |=> fetch_pointer_o == $past(vector_i); endproperty
  a_vec: assert property (p_vec) else $error("vector not loaded");
  property p_push; call_i && !stack_busy_o && !int_entry_i |=>
    stack_busy_o ##[5:6] stack_done_o; endproperty
  a_push: assert property (p_push) else $error("push timing wrong");
  property p_alu4; alu_go_i && !alu_wide_i |=> alu_done_o; endproperty
  a_alu4: assert property (p_alu4) else $error("nibble op not one cycle");
  property p_alu8; alu_go_i && alu_wide_i |=> !alu_done_o ##1 alu_done_o; endproperty
  a_alu8: assert property (p_alu8) else $error("byte op not two cycles");
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("register access not answered");
  c_call: cover property (call_i && !stack_busy_o);
  c_ref: cover property (f_ok && table_ref_i);
  c_alu8: cover property (alu_go_i && alu_wide_i);
endmodule : cpu_state_assertions
bind cpu_state cpu_state_assertions cpu_state_assertions_i (.*);

// ### testbench/cpu_state_bench.sv
module cpu_state_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 1'b0, rst_i = 1'b1;
  logic fetch, tref, call, intr, ret, areq, ago, awide, skl, sml, cyc, stb, we, ack;
  logic busy, sd, ad, yd, ae, tok, terr;
  logic [1:0] flen, l;
  logic [13:0] vec, tgt, exp_fp, fp;
  logic [7:0] adr, aa, ab, program_state_word, sp, rd, y;
  logic [31:0] dat, rdat;
  logic [2:0] skp;
  logic [3:0] memory_bank_select;
  logic [11:0] base;
  logic [15:0] r;
  logic [31:0] q[$];
  integer seed = 58, fails = 0, num_checks = 0;
  cpu_state cpu_state_i (.clk_i, .rst_i, .fetch_i(fetch), .fetch_len_i(flen), .table_ref_i(tref),
    .ref_addr_i(tgt), .ref_len_i(flen), .call_i(call), .call_target_i(tgt), .int_entry_i(intr),
    .vector_i(vec), .ret_i(ret), .acc_req_i(areq), .acc_we_i(we), .acc_reg_i(1'b0),
    .acc_ind_i(1'b0), .acc_size_i(flen), .acc_addr_i(adr), .acc_bit_i(skp),
    .acc_wdata_i(dat[7:0]), .alu_go_i(ago), .alu_wide_i(awide), .alu_op_i(cpu_state_pkg::ALU_ADD),
    .alu_a_i(aa), .alu_b_i(ab), .skip_load_i(skl), .skip_i(skp), .smb_load_i(sml), .smb_i(memory_bank_select),
    .srb_load_i(sml), .srb_i(memory_bank_select[3:2]), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_ack_o(ack), .wb_dat_o(rdat),
    .fetch_pointer_o(fp), .program_state_word_o(program_state_word), .stack_index_o(sp), .bank_base_o(base),
    .stack_busy_o(busy), .stack_done_o(sd), .acc_done_o(ad), .acc_err_o(ae), .acc_rdata_o(rd),
    .alu_done_o(yd), .alu_y_o(y), .tref_ok_o(tok), .tref_err_o(terr));
  initial forever #2.5 clk_i = ~clk_i;
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic print_verdict;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  // Master holds the request until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
    if (!w) q.push_back(e);
    @(posedge clk_i);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    {cyc, stb, we} <= 3'b000;
  endtask : wb
  task automatic stack_cmd(input logic [2:0] c);
    @(posedge clk_i);
    {call, ret, intr} <= c;
    @(posedge clk_i);
    {call, ret, intr} <= 3'b000;
    do @(posedge clk_i); while (sd !== 1'b1);
    @(posedge clk_i);
  endtask : stack_cmd
  // Data access is a one-cycle pulse; expected {err, rdata} is queued
  task automatic acc(input logic w, input logic [1:0] s, input logic [7:0] a,
                     input logic [7:0] d, input logic [8:0] e);
    q.push_back({23'h0, e});
    @(posedge clk_i);
    {areq, we, flen, adr, dat} <= {1'b1, w, s, a, 24'h0, d};
    @(posedge clk_i);
    {areq, we} <= 2'b00;
    @(posedge clk_i);
  endtask : acc
  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0) check("wb_dat", rdat, q.pop_front());
    if (ad === 1'b1) check("acc", {23'h0, ae, rd}, q.pop_front());
    if (tok === 1'b1 || terr === 1'b1) check("tref", {30'h0, tok, terr}, q.pop_front());
    if (yd === 1'b1) check("alu_y", {24'h0, y}, q.pop_front());
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    print_verdict();
  end
  initial begin
    {fetch, tref, call, intr, ret, areq, ago, awide, skl, sml, cyc, stb, we} = '0;
    {flen, vec, tgt, adr, aa, ab, dat, skp, memory_bank_select, exp_fp} = '0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check("fp_reset", fp, 32'h0);
    acc(1, 2'h2, 8'h80, 8'hFF, 9'h000);
    wb(1, 8'h0C, 32'h00, 0);
    wb(0, 8'h0C, 0, 32'hFE);
    acc(1, 2'h2, 8'h80, 8'h00, 9'h0FE);
    acc(1, 2'h1, 8'hB1, 8'h0F, 9'h000);
    acc(1, 2'h1, 8'hB0, 8'h0F, 9'h000);
    acc(1, 2'h2, 8'hB0, 8'h00, 9'h100);
    wb(1, 8'h08, 32'h00, 0);
    wb(0, 8'h08, 0, 32'hF8);
    wb(0, 8'h40, 0, 32'h0);
    wb(1, 8'h00, 32'h0F, 0);
    wb(1, 8'h00, 32'h03, 0);
    wb(0, 8'h00, 0, 32'h0F);
    check("bank_base", base, 32'hF00);
    @(posedge clk_i);
    {skl, skp} <= 4'hD;
    @(posedge clk_i);
    skl <= 1'b0;
    wb(0, 8'h08, 0, 32'hFD);
    acc(0, 2'h2, 8'hB0, 8'h00, 9'h0FD);
    {sml, memory_bank_select} <= {1'b1, 4'h1};
    @(posedge clk_i);
    sml <= 1'b0;
    @(posedge clk_i);
    check("bank_base", base, 32'h100);
    wb(1, 8'h0C, 0, 0);
    tgt <= 14'h0020;
    for (int i = 0; i < 8; i++) begin
      l = 2'($random(seed));
      if (l == 2'h0) l = 2'h1;
      if (i == 3) q.push_back({30'h0, l != 2'h3, l == 2'h3});
      {fetch, tref, flen} <= {1'b1, i == 3, l};
      if (i != 3) exp_fp += 14'(l);
      @(posedge clk_i);
    end
    fetch <= 1'b0;
    wb(0, 8'h04, 0, {18'h0, exp_fp});
    tgt <= 14'h1234;
    stack_cmd(3'b100);
    check("sp_push", sp, 32'hFA);
    check("fp_call", fp, 32'h1234);
    stack_cmd(3'b010);
    check("fp_ret", fp, {18'h0, exp_fp});
    check("psw_ret", program_state_word, 32'hFD);
    vec <= 14'h0008;
    stack_cmd(3'b001);
    check("fp_vec", fp, 32'h8);
    for (int k = 0; k < 2; k++) begin
      wb(1, 8'h08, 0, 0);
      r = 16'($random(seed));
      q.push_back(k ? 32'(8'(r[15:8] + r[7:0])) : 32'(4'(r[11:8] + r[3:0])));
      {ago, awide, aa, ab} <= {1'b1, k[0], r};
      @(posedge clk_i);
      ago <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
    check("pending", q.size(), 0);
    print_verdict();
  end
endmodule : cpu_state_bench
